// ===== core/lcd_panel_timing_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_timing_power_ctrl #(
    parameter int PIX_W = 12
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic [lcd_timing_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [lcd_timing_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic gp_pin_zero_in,
    output logic gp_pin_zero_out,
    output logic gp_pin_zero_oe_out,
    input wire logic [PIX_W-1:0] pixel_data_in,
    output logic [PIX_W-1:0] panel_pixel_bus_out,
    output logic panel_power_out,
    output logic line_pulse_out,
    output logic frame_pulse_out,
    output logic display_enable_out,
    output logic power_save_out
);
    import lcd_timing_pkg::*;

    // Whole module state: registers, bus slave and power sequencer
    typedef struct packed {
        logic panel_am;          // Active matrix panel select
        logic [3:0] pwr_mode;    // Override, hw save enable, sw save code
        logic [6:0] hsize;
        logic [9:0] vsize;
        logic [4:0] lp_start;
        logic [4:0] hblank;
        logic [5:0] fp_start;
        logic [5:0] vblank;
        logic gp_cfg;            // Pin zero drives when set and hw save enable is clear
        logic gp_ctl;            // Value driven on pin zero
        logic aw_have;           // Write address held
        logic w_have;            // Write data held
        logic [IDX_W-1:0] aw_idx;
        logic [7:0] wbyte;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        pwr_state_t pstate;
        logic [PIX_W-1:0] pixbus;
    } state_t;

    state_t st_r, st_nxt;
    logic ps_req;          // Power save requested by software or pin
    logic hw_ps_en, ovr;   // Decoded mode bits
    logic sig_on;          // Panel signals allowed to toggle
    logic aw_fire, w_fire, ar_fire;
    logic [IDX_W-1:0] ar_idx;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic tim_lp, tim_fp, tim_de, tim_vnd, tim_fend;

    // Mode bits straight from the register
    assign hw_ps_en = st_r.pwr_mode[HW_PS_EN_BIT];
    assign ovr = st_r.pwr_mode[PWR_OVR_BIT];
    // Reserved software codes are treated as normal operation
    assign ps_req = (st_r.pwr_mode[1:0] == SW_PS_SAVE) || (hw_ps_en && gp_pin_zero_in);
    // Panel is up in all states but off
    assign sig_on = st_r.pstate != PWR_OFF;

    // Ready outputs are combinational; all three are held off while the clock is gated
    assign s_axi_awready_out = ce_in && !st_r.aw_have && !st_r.bvalid;
    assign s_axi_wready_out = ce_in && !st_r.w_have && !st_r.bvalid;
    assign s_axi_arready_out = ce_in && !st_r.rvalid;
    assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
    assign w_fire = s_axi_wvalid_in && s_axi_wready_out;
    assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
    assign ar_idx = s_axi_araddr_in[ADDR_W-1:2];

    // Read decode; byte registers sit in the low lane, upper bits read zero
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (ar_idx)
            IDX_PANEL_CFG: rd_byte = {st_r.panel_am, 7'h00};
            IDX_POWER_MODE: rd_byte = {4'h0, st_r.pwr_mode};
            IDX_HSIZE: rd_byte = {1'b0, st_r.hsize};
            IDX_VSIZE_LO: rd_byte = st_r.vsize[7:0];
            IDX_VSIZE_HI: rd_byte = {6'h00, st_r.vsize[9:8]};
            IDX_LP_START: rd_byte = {3'h0, st_r.lp_start};
            IDX_HBLANK: rd_byte = {3'h0, st_r.hblank};
            IDX_FP_START: rd_byte = {2'h0, st_r.fp_start};
            IDX_VBLANK: rd_byte = {tim_vnd, 1'b0, st_r.vblank};
            IDX_GP_CONFIG: rd_byte = {7'h00, st_r.gp_cfg};
            // Input mode returns the pin; output mode returns the driven value
            IDX_GP_STATUS: rd_byte = {7'h00, st_r.gp_cfg ? st_r.gp_ctl : gp_pin_zero_in};
            default: rd_hit = 1'b0;
        endcase
    end

    // Next state of the whole module
    always_comb begin
        st_nxt = st_r;

        // Write channel: address and data taken in either order
        if (aw_fire) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_idx = s_axi_awaddr_in[ADDR_W-1:2];
        end
        if (w_fire) begin
            st_nxt.w_have = 1'b1;
            st_nxt.wbyte = s_axi_wdata_in[7:0];
            st_nxt.wlane0 = s_axi_wstrb_in[0];
        end
        // Both halves held: commit, answer
        if (st_r.aw_have && st_r.w_have) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            // A write without lane 0 changes nothing but still answers
            case (st_r.aw_idx)
                IDX_PANEL_CFG: if (st_r.wlane0) st_nxt.panel_am = st_r.wbyte[PANEL_AM_BIT];
                IDX_POWER_MODE: if (st_r.wlane0) st_nxt.pwr_mode = st_r.wbyte[3:0];
                IDX_HSIZE: if (st_r.wlane0) st_nxt.hsize = st_r.wbyte[6:0];
                IDX_VSIZE_LO: if (st_r.wlane0) st_nxt.vsize[7:0] = st_r.wbyte;
                IDX_VSIZE_HI: if (st_r.wlane0) st_nxt.vsize[9:8] = st_r.wbyte[1:0];
                IDX_LP_START: if (st_r.wlane0) st_nxt.lp_start = st_r.wbyte[4:0];
                IDX_HBLANK: if (st_r.wlane0) st_nxt.hblank = st_r.wbyte[4:0];
                IDX_FP_START: if (st_r.wlane0) st_nxt.fp_start = st_r.wbyte[5:0];
                // Status bit is read-only; only the period field is written
                IDX_VBLANK: if (st_r.wlane0) st_nxt.vblank = st_r.wbyte[5:0];
                IDX_GP_CONFIG: if (st_r.wlane0) st_nxt.gp_cfg = st_r.wbyte[0];
                IDX_GP_STATUS: if (st_r.wlane0) st_nxt.gp_ctl = st_r.wbyte[0];
                default: st_nxt.bresp = RESP_DECERR;
            endcase
        end
        // Response stands until taken
        if (st_r.bvalid && s_axi_bready_in) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel: one read at a time, answer one clock after address
        if (ar_fire) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = {24'h000000, rd_byte};
            st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (st_r.rvalid && s_axi_rready_in) begin
            st_nxt.rvalid = 1'b0;
        end

        // Power sequencer
        case (st_r.pstate)
            PWR_OFF: begin
                // Wake once nothing asks for save
                if (!ps_req) begin
                    st_nxt.pstate = PWR_ON;
                end
            end
            PWR_ON: begin
                // Override skips the drain
                if (ps_req && ovr) begin
                    st_nxt.pstate = PWR_OFF;
                end else if (ps_req) begin
                    st_nxt.pstate = PWR_DRAIN;
                end
            end
            PWR_DRAIN: begin
                // Finish the frame before power off; override cuts it short
                if (!ps_req) begin
                    st_nxt.pstate = PWR_ON;
                end else if (ovr || tim_fend) begin
                    st_nxt.pstate = PWR_OFF;
                end
            end
            default: st_nxt.pstate = PWR_OFF;
        endcase

        // Pixel bus low whenever the panel is off or outside active area
        if (st_nxt.pstate != PWR_OFF && tim_de) begin
            st_nxt.pixbus = pixel_data_in;
        end else begin
            st_nxt.pixbus = '0;
        end
    end

    // One register for all state, frozen while the clock enable is low
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
            // Fields with named reset values
            st_r.pwr_mode <= RST_POWER_MODE[3:0];
            st_r.hsize <= RST_TIMING[6:0];
            st_r.pstate <= PWR_OFF;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    // Panel timing runs only while the sequencer keeps the panel up
    panel_timing_gen u_timing (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .run_in(sig_on),
        .active_matrix_in(st_r.panel_am),
        .hsize_in(st_r.hsize),
        .vsize_in(st_r.vsize),
        .lp_start_in(st_r.lp_start),
        .hblank_in(st_r.hblank),
        .fp_start_in(st_r.fp_start),
        .vblank_in(st_r.vblank),
        .line_pulse_out(tim_lp),
        .frame_pulse_out(tim_fp),
        .display_en_out(tim_de),
        .vnd_status_out(tim_vnd),
        .frame_end_out(tim_fend)
    );

    // Outputs
    assign s_axi_bvalid_out = st_r.bvalid;
    assign s_axi_bresp_out = st_r.bresp;
    assign s_axi_rvalid_out = st_r.rvalid;
    assign s_axi_rdata_out = st_r.rdata;
    assign s_axi_rresp_out = st_r.rresp;
    assign panel_power_out = sig_on;
    // Gated so nothing toggles while off
    assign line_pulse_out = sig_on && tim_lp;
    assign frame_pulse_out = sig_on && tim_fp;
    assign display_enable_out = sig_on && tim_de;
    assign panel_pixel_bus_out = st_r.pixbus;
    assign power_save_out = ps_req;
    // Pin zero never drives while it serves as the save input
    assign gp_pin_zero_oe_out = !hw_ps_en && st_r.gp_cfg;
    assign gp_pin_zero_out = st_r.gp_ctl;

    // Sequencer, bus and pin checks
    seq_drain_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && !ovr && ps_req && st_r.pstate == PWR_ON) |=>
        (panel_power_out && st_r.pstate == PWR_DRAIN))
        else $error("sequencer did not drain before power off");

    ovr_force_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && ovr && ps_req) |=> (!panel_power_out && !line_pulse_out
        && !frame_pulse_out && panel_pixel_bus_out == '0))
        else $error("override did not force panel off");

    hw_save_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (hw_ps_en && gp_pin_zero_in) |-> (power_save_out && !gp_pin_zero_oe_out))
        else $error("pin zero not acting as save input");

    gp_dir_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !hw_ps_en |-> (gp_pin_zero_oe_out == st_r.gp_cfg))
        else $error("pin zero direction does not follow config");

    sw_save_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (st_r.pwr_mode[1:0] == SW_PS_SAVE) |-> power_save_out)
        else $error("software save code not honoured");

    sw_normal_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (st_r.pwr_mode[1:0] == SW_PS_NORMAL && !hw_ps_en) |-> !power_save_out)
        else $error("normal code still in power save");

    vsize_hi_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && st_r.aw_have && st_r.w_have && st_r.wlane0 && st_r.aw_idx == IDX_VSIZE_HI)
        |=> (st_r.vsize[9:8] == $past(st_r.wbyte[1:0])))
        else $error("upper height bits not stored");

    off_quiet_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (st_r.pstate == PWR_OFF) |-> (!line_pulse_out && panel_pixel_bus_out == '0))
        else $error("panel not quiet while off");
endmodule
`default_nettype wire

// ===== core/lcd_timing_pkg.sv
package lcd_timing_pkg;

    // Bus geometry: register index sits in address bits above the word offset
    localparam int ADDR_W = 20;
    localparam int IDX_W = 18;

    // Register indexes; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PANEL_CFG = 18'h1FFE1;
    localparam logic [IDX_W-1:0] IDX_POWER_MODE = 18'h1FFE3;
    localparam logic [IDX_W-1:0] IDX_HSIZE = 18'h1FFE4;
    localparam logic [IDX_W-1:0] IDX_VSIZE_LO = 18'h1FFE5;
    localparam logic [IDX_W-1:0] IDX_VSIZE_HI = 18'h1FFE6;
    localparam logic [IDX_W-1:0] IDX_LP_START = 18'h1FFE7;
    localparam logic [IDX_W-1:0] IDX_HBLANK = 18'h1FFE8;
    localparam logic [IDX_W-1:0] IDX_FP_START = 18'h1FFE9;
    localparam logic [IDX_W-1:0] IDX_VBLANK = 18'h1FFEA;
    localparam logic [IDX_W-1:0] IDX_GP_CONFIG = 18'h1FFF8;
    localparam logic [IDX_W-1:0] IDX_GP_STATUS = 18'h1FFF9;

    // Field positions
    localparam int PANEL_AM_BIT = 7;
    localparam int PWR_OVR_BIT = 3;
    localparam int HW_PS_EN_BIT = 2;
    localparam int VND_STATUS_BIT = 7;

    // Reset values of the software registers
    localparam logic [7:0] RST_POWER_MODE = 8'h00;
    localparam logic [7:0] RST_TIMING = 8'h00;

    // Software power save codes
    localparam logic [1:0] SW_PS_SAVE = 2'b00;
    localparam logic [1:0] SW_PS_NORMAL = 2'b11;

    // Timing arithmetic: 8-pixel units and fixed offsets of the fields
    localparam int UNIT_SHIFT = 3;
    localparam logic [10:0] UNIT_PIXELS = 11'h008;
    localparam logic [5:0] LP_OFFSET = 6'h02;
    localparam logic [5:0] HND_OFFSET = 6'h04;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // Panel power sequencer, one-hot
    typedef enum logic [2:0] {
        PWR_OFF = 3'b001,
        PWR_ON = 3'b010,
        PWR_DRAIN = 3'b100
    } pwr_state_t;

endpackage

// ===== core/panel_timing_gen.sv
`timescale 1ns/1ps
`default_nettype none
module panel_timing_gen (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic run_in,
    input wire logic active_matrix_in,
    input wire logic [6:0] hsize_in,
    input wire logic [9:0] vsize_in,
    input wire logic [4:0] lp_start_in,
    input wire logic [4:0] hblank_in,
    input wire logic [5:0] fp_start_in,
    input wire logic [5:0] vblank_in,
    output logic line_pulse_out,
    output logic frame_pulse_out,
    output logic display_en_out,
    output logic vnd_status_out,
    output logic frame_end_out
);
    import lcd_timing_pkg::*;

    // Counters and registered panel timing flags
    typedef struct packed {
        logic [10:0] pix;
        logic [10:0] line;
        logic lp;
        logic fp;
        logic de;
        logic vnd;
        logic fend;
    } tstate_t;

    tstate_t st_r, st_nxt;
    logic [10:0] h_act, h_tot, lp_pos, v_act, v_tot, fp_line; // Derived geometry
    logic last_pix, last_line;

    // Geometry from fields; widths kept at 11 bits to cover 1024 plus blanking
    assign h_act = 11'((11'(hsize_in) + 11'h001) << UNIT_SHIFT);
    assign h_tot = h_act + 11'((11'(hblank_in) + 11'(HND_OFFSET)) << UNIT_SHIFT);
    // Passive panels pulse right at end of data; offset applies to active matrix
    assign lp_pos = active_matrix_in ?
        h_act + 11'((11'(lp_start_in) + 11'(LP_OFFSET)) << UNIT_SHIFT) : h_act;
    assign v_act = 11'(vsize_in) + 11'h001;
    assign v_tot = v_act + 11'(vblank_in);
    assign fp_line = v_act + 11'(fp_start_in) - 11'h001;
    assign last_pix = st_r.pix == h_tot - 11'h001;
    assign last_line = st_r.line == v_tot - 11'h001;

    // Next state: counters advance while running, clear while stopped
    always_comb begin
        st_nxt = st_r;
        if (!run_in) begin
            st_nxt = '0;
        end else begin
            st_nxt.fend = 1'b0;
            if (last_pix) begin
                st_nxt.pix = 11'h000;
                if (last_line) begin
                    st_nxt.line = 11'h000;
                    st_nxt.fend = 1'b1;
                end else begin
                    st_nxt.line = st_r.line + 11'h001;
                end
            end else begin
                st_nxt.pix = st_r.pix + 11'h001;
            end
            // Flags lag the counters by one clock, uniformly for all outputs
            st_nxt.de = (st_r.pix < h_act) && (st_r.line < v_act);
            st_nxt.lp = (st_r.pix >= lp_pos) && (st_r.pix < lp_pos + UNIT_PIXELS);
            if (active_matrix_in) begin
                st_nxt.fp = st_r.line == fp_line;
            end else begin
                st_nxt.fp = st_r.line == 11'h000;
            end
            st_nxt.vnd = st_r.line >= v_act;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign line_pulse_out = st_r.lp;
    assign frame_pulse_out = st_r.fp;
    assign display_en_out = st_r.de;
    assign vnd_status_out = st_r.vnd;
    assign frame_end_out = st_r.fend;

    h_wrap_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && run_in && last_pix) |=> (st_r.pix == 11'h000))
        else $error("pixel counter did not wrap at line total");
    v_max_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (vsize_in == 10'h3FF) |-> (v_act == 11'h400))
        else $error("largest vertical size is not 1024 lines");
    frame_len_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && run_in && last_pix && last_line) |=> (st_r.line == 11'h000 && st_r.fend))
        else $error("frame did not end after blank lines");
    vnd_flag_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && run_in) |=> (st_r.vnd == ($past(st_r.line) >= v_act)))
        else $error("vertical blank status wrong");
    lp_place_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && run_in && active_matrix_in && st_r.pix == lp_pos) |=> st_r.lp)
        else $error("line pulse missing at its position");
    fp_place_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && run_in && active_matrix_in && st_r.line == fp_line) |=> st_r.fp)
        else $error("frame pulse missing on its line");
    de_width_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (ce_in && run_in && st_r.pix == h_act && st_r.line == 11'h000) |=> !st_r.de)
        else $error("display enable runs past active width");
endmodule
`default_nettype wire

// ===== tb/lcd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// Panel side: resolves pin zero and measures line and frame geometry in clocks
module lcd_panel_model (
    input wire logic clock_in,
    input wire logic line_pulse_in,
    input wire logic frame_pulse_in,
    input wire logic display_enable_in,
    input wire logic board_level_in,
    input wire logic pin_drive_in,
    input wire logic pin_oe_in,
    output logic pin_level_out,
    output int line_out,
    output int width_out,
    output int lp_delay_out,
    output int frame_out,
    output int fp_to_de_out
);
    int cyc = 0, lp_at = 0, fall_at = 0, fp_at = 0, run = 0;
    logic lp_q = 0, fp_q = 0, de_q = 0, fell = 0, fp_seen = 0;
    // The board level shows only while the controller leaves the pin undriven
    assign pin_level_out = pin_oe_in ? pin_drive_in : board_level_in;
    // Edges are found against the previous clock, so every delta shares one lag
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        {lp_q, fp_q, de_q} <= {line_pulse_in, frame_pulse_in, display_enable_in};
        run <= display_enable_in ? run + 1 : 0;
        // End of display data on this line
        if (de_q && !display_enable_in) begin
            width_out <= run;
            fall_at <= cyc;
            fell <= 1'b1;
        end
        // Blank lines carry no data edge, so their pulse delay is ignored
        if (line_pulse_in && !lp_q) begin
            line_out <= cyc - lp_at;
            lp_at <= cyc;
            if (fell) lp_delay_out <= cyc - fall_at;
            fell <= 1'b0;
        end
        if (frame_pulse_in && !fp_q) begin
            frame_out <= cyc - fp_at;
            fp_at <= cyc;
            fp_seen <= 1'b1;
        end
        if (display_enable_in && !de_q && fp_seen) begin
            fp_to_de_out <= cyc - fp_at;
            fp_seen <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_lcd_panel_timing_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_lcd_panel_timing_power_ctrl;
    import lcd_timing_pkg::*;
    // Smallest legal width keeps frames short
    localparam int HS = 3, HB = 1, LP = 1, VS = 3, VB = 2;
    localparam int LINE = (HS + 1) * 8 + (HB + 4) * 8;
    localparam int FRAME = (VS + 1 + VB) * LINE;
    logic clock_in = 0, sys_rst_in = 1, board = 0;
    logic [19:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdq, rdata;
    logic [11:0] pix = 0, bus;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pin, pin_o, pin_oe;
    logic power, lp, fp, de, ps, aw_t, w_t, b_t, ar_t, r_t;
    logic [1:0] bresp, rresp, bsq, rsq;
    int fail_count = 0, samples_checked = 0, line_m, width_m, lpd_m, frame_m, fpde_m, f1;
    always #20 clock_in = ~clock_in;
    lcd_panel_timing_power_ctrl lcd_panel_timing_power_ctrl_i (
        .clock_in, .sys_rst_in, .ce_in(1'b1),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .gp_pin_zero_in(pin),
        .gp_pin_zero_out(pin_o), .gp_pin_zero_oe_out(pin_oe), .pixel_data_in(pix),
        .panel_pixel_bus_out(bus), .panel_power_out(power), .line_pulse_out(lp),
        .frame_pulse_out(fp), .display_enable_out(de), .power_save_out(ps));
    lcd_panel_model lcd_panel_model_i (
        .clock_in, .line_pulse_in(lp), .frame_pulse_in(fp), .display_enable_in(de),
        .board_level_in(board), .pin_drive_in(pin_o), .pin_oe_in(pin_oe),
        .pin_level_out(pin), .line_out(line_m), .width_out(width_m),
        .lp_delay_out(lpd_m), .frame_out(frame_m), .fp_to_de_out(fpde_m));
    // Handshakes are judged on the values present at the edge itself
    always @(posedge clock_in) begin
        {aw_t, w_t, b_t} <= {awvalid & awready, wvalid & wready, bvalid & bready};
        {ar_t, r_t} <= {arvalid & arready, rvalid & rready};
        {rdq, rsq, bsq} <= {rdata, rresp, bresp};
        pix <= pix + 12'h001;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Address and data offered together, each released once taken
    task automatic wr(input logic [17:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge clock_in);
            #1;
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            n++;
        end while (!b_t && n < 40);
        check(b_t, 1'b1, "write answer");
        check(bsq, er, "write response");
    endtask
    task automatic rd(input logic [17:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= {idx, 2'b00};
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge clock_in);
            #1;
            if (ar_t) arvalid <= 1'b0;
            n++;
        end while (!r_t && n < 40);
        check(r_t, 1'b1, "read answer");
        d = rdq;
        r = rsq;
    endtask
    // Upper 24 bits must read zero as well
    task automatic rchk(input logic [17:0] idx, input logic [7:0] m, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        check({d[31:8], d[7:0] & m}, {24'h000000, e}, "read data");
    endtask
    task automatic wait_for(ref logic s, input logic lvl);
        int n;
        n = 0;
        while (s !== lvl && n < 2000) begin
            @(posedge clock_in);
            #1;
            n++;
        end
    endtask
    task automatic test_regs();
        logic [31:0] d;
        logic [1:0] r;
        rchk(IDX_POWER_MODE, 8'hFF, RST_POWER_MODE);
        check(power, 1'b0, "panel off in save");
        rchk(IDX_HSIZE, 8'hFF, RST_TIMING);
        rd(18'h00010, d, r);
        check({r, d[29:0]}, {RESP_DECERR, 30'h0}, "unmapped read");
        wr(18'h00010, 8'h55, RESP_DECERR);
        wr(IDX_VSIZE_LO, 8'hFF, RESP_OKAY);
        wr(IDX_VSIZE_HI, 8'h03, RESP_OKAY);
        rchk(IDX_VSIZE_LO, 8'hFF, 8'hFF);
        rchk(IDX_VSIZE_HI, 8'h03, 8'h03);
        wr(IDX_VBLANK, 8'h7F, RESP_OKAY);
        rchk(IDX_VBLANK, 8'h7F, 8'h3F);
        $display("registers test done");
    endtask
    task automatic test_timing();
        wr(IDX_PANEL_CFG, 8'h80, RESP_OKAY);
        wr(IDX_HSIZE, 8'(HS), RESP_OKAY);
        wr(IDX_HBLANK, 8'(HB), RESP_OKAY);
        wr(IDX_LP_START, 8'(LP), RESP_OKAY);
        wr(IDX_VSIZE_LO, 8'(VS), RESP_OKAY);
        wr(IDX_VSIZE_HI, 8'h00, RESP_OKAY);
        wr(IDX_VBLANK, 8'(VB), RESP_OKAY);
        wr(IDX_FP_START, 8'h01, RESP_OKAY);
        wr(IDX_POWER_MODE, 8'h03, RESP_OKAY);
        repeat (3 * FRAME) @(posedge clock_in);
        check(line_m, LINE, "line period");
        check(width_m, (HS + 1) * 8, "active width");
        check(lpd_m, (LP + 2) * 8, "line pulse delay");
        check(frame_m, FRAME, "frame period");
        f1 = fpde_m;
        wait_for(fp, 1'b1);
        rchk(IDX_VBLANK, 8'h80, 8'h80);
        wait_for(de, 1'b1);
        @(posedge clock_in);
        #1;
        check(bus, 12'(pix - 12'h001), "pixel data");
        rchk(IDX_VBLANK, 8'h80, 8'h00);
        wr(IDX_FP_START, 8'(VB), RESP_OKAY);
        repeat (3 * FRAME) @(posedge clock_in);
        check(f1 - fpde_m, (VB - 1) * LINE, "frame pulse shift");
        $display("timing test done");
    endtask
    task automatic test_power();
        wait_for(fp, 1'b1);
        wr(IDX_POWER_MODE, 8'h00, RESP_OKAY);
        check(power, 1'b1, "power held to frame end");
        wait_for(power, 1'b0);
        check({power, ps}, 2'b01, "sequenced off");
        wr(IDX_POWER_MODE, 8'h03, RESP_OKAY);
        repeat (FRAME) @(posedge clock_in);
        check(power, 1'b1, "powered again");
        wr(IDX_POWER_MODE, 8'h08, RESP_OKAY);
        repeat (2) @(posedge clock_in);
        check({power, lp, fp, de, bus}, 16'h0000, "forced off");
        for (int c = 0; c < 4; c++) begin
            wr(IDX_POWER_MODE, 8'(c), RESP_OKAY);
            check(ps, c == 0, "save code");
        end
        $display("power test done");
    endtask
    task automatic test_gp();
        wr(IDX_GP_CONFIG, 8'h00, RESP_OKAY);
        board <= 1'b1;
        rchk(IDX_GP_STATUS, 8'h01, 8'h01);
        board <= 1'b0;
        rchk(IDX_GP_STATUS, 8'h01, 8'h00);
        check(pin_oe, 1'b0, "pin input");
        wr(IDX_GP_CONFIG, 8'h01, RESP_OKAY);
        wr(IDX_GP_STATUS, 8'h01, RESP_OKAY);
        check({pin_oe, pin_o}, 2'b11, "pin output");
        wr(IDX_POWER_MODE, 8'h07, RESP_OKAY);
        check(pin_oe, 1'b0, "save input");
        board <= 1'b1;
        repeat (2) @(posedge clock_in);
        check(ps, 1'b1, "pin high saves");
        board <= 1'b0;
        repeat (2) @(posedge clock_in);
        check(ps, 1'b0, "pin low runs");
        $display("pin test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        test_regs();
        test_timing();
        test_power();
        test_gp();
        tally_and_finish();
    end
    // Whole run is near 9 frames plus bus traffic
    initial begin
        repeat (12 * FRAME + 4000) @(posedge clock_in);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
